// ---- core/dshi_pkg.sv ----
// Purpose: constants and types for the serial host interface of a multichannel DAC
// Assumes: AXI4-Lite register access at 32-bit words, pins sampled by aclk
// Notes: the serial pins arrive asynchronous to aclk and are synchronised in the core
// Behaviour
// - accept 24-bit MSB-first command word
// - bank bit picks A/B only in toggle
// - chain enable low standalone, high daisy chain
// - standalone works with free or gated clock
// - frame sync fall starts cycle, clears count
// - standalone ignores sync rise, sclk after 24
// - daisy shifts always, excess bits spill out
// - data out changes on rising serial clock
// - daisy sync rise latches word, stops shifting
// - daisy sync rise before 24 clocks discards frame
// - read bit set means readback request decoded
// - next frame returns data, echoes 10 address bits
// - all-zero frame is a no-operation
// - readback framed by sync, rising edge output
// - sclk idle high: first bit at sync fall

package dshi_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_LAST_CMD = 12'h008;
  localparam logic [11:0] REG_GOOD_CNT = 12'h00C;
  localparam logic [11:0] REG_BAD_CNT = 12'h010;
  localparam logic CTRL_TOGGLE_RST = 1'h0;
  localparam int CTRL_TOGGLE_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // serial word
  // ----------------------------------------------------------------
  localparam logic [4:0] WORD_BITS = 5'h18;
  localparam logic [23:0] NO_OPERATION_WORD = 24'h000000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  typedef struct packed {
    logic bank;
    logic rd;
    logic [5:0] channel_address;
    logic register_target_hi;
    logic register_target_lo;
    logic [11:0] data_word;
    logic [1:0] pad;
  } dshi_cmd_t;

  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic din;
    logic chain_enable;
    logic serial_parallel_select;
    logic protocol_select;
  } dshi_pins_t;

  // sync_n idles high
  localparam dshi_pins_t PINS_RST = 6'h10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_FULL = 2'h3
  } dshi_state_t;

endpackage

// ---- core/dshi_serial.sv ----
// Purpose: serial write and readback port of a multichannel DAC, with AXI4-Lite control
// Assumes: serial clock period of at least 8 aclk cycles; pins asynchronous to aclk
// Notes: data store is 512 x 12 indexed by bank, target and channel address
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

module dshi_serial (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dshi_pkg::dshi_pins_t pins,
  output logic chain_data_out,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import dshi_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dshi_pins_t meta_r, sync_r, prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= PINS_RST;
      sync_r <= PINS_RST;
      prev_r <= PINS_RST;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges found from samples, so a stopped or free clock behave alike
  logic sclk_fall, sclk_rise, frm_fall, frm_rise, serial_on, daisy;
  assign sclk_fall = prev_r.sclk & ~sync_r.sclk;
  assign sclk_rise = ~prev_r.sclk & sync_r.sclk;
  assign frm_fall = prev_r.sync_n & ~sync_r.sync_n;
  assign frm_rise = ~prev_r.sync_n & sync_r.sync_n;
  assign serial_on = sync_r.serial_parallel_select & ~sync_r.protocol_select;
  assign daisy = sync_r.chain_enable;

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  dshi_state_t state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] sr_r, sr_nxt, rb_word_r, rb_word_nxt, last_cmd_r, last_cmd_nxt, preload;
  logic dout_r, dout_nxt, rb_pend_r, rb_pend_nxt, toggle_r, toggle_nxt;
  logic [15:0] good_cnt_r, good_cnt_nxt, bad_cnt_r, bad_cnt_nxt;
  logic exec_go, mem_we;
  logic [23:0] exec_word;
  dshi_cmd_t cmd;
  logic [8:0] mem_idx;
  logic [11:0] mem_q;
  logic [11:0] mem [0:511];

  assign preload = rb_pend_r ? rb_word_r : NO_OPERATION_WORD;
  assign cmd = exec_word;
  // bank bit only counts with toggle on
  assign mem_idx = {cmd.bank & toggle_r, cmd.register_target_hi, cmd.register_target_lo, cmd.channel_address};
  assign mem_q = mem[mem_idx];

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sr_nxt = sr_r;
    dout_nxt = dout_r;
    exec_go = 1'b0;
    exec_word = sr_r;
    bad_cnt_nxt = bad_cnt_r;
    if (!serial_on) begin
      state_nxt = ST_IDLE;
    end else if (frm_fall) begin
      // new frame: count cleared, readback word preloaded
      state_nxt = ST_SHIFT;
      cnt_nxt = 5'h00;
      sr_nxt = preload;
      if (sync_r.sclk) begin
        dout_nxt = preload[23];
      end
    end else begin
      case (state_r)
        ST_SHIFT: begin
          if (frm_rise && daisy) begin
            state_nxt = ST_IDLE;
            if (cnt_r == WORD_BITS) begin
              exec_go = 1'b1;
            end else begin
              bad_cnt_nxt = bad_cnt_r + 16'h0001;
            end
          end else if (sclk_fall) begin
            // MSB first, sampled on falling edge
            sr_nxt = {sr_r[22:0], sync_r.din};
            if (cnt_r != WORD_BITS) begin
              cnt_nxt = cnt_r + 5'h01;
            end
            if (!daisy && cnt_r == WORD_BITS - 5'h01) begin
              state_nxt = ST_FULL;
              exec_go = 1'b1;
              exec_word = sr_nxt;
            end
          end else if (sclk_rise) begin
            dout_nxt = sr_r[23];
          end
        end
        ST_FULL: begin
          state_nxt = ST_FULL;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // command execution
  always_comb begin
    rb_word_nxt = rb_word_r;
    last_cmd_nxt = last_cmd_r;
    good_cnt_nxt = good_cnt_r;
    mem_we = 1'b0;
    // pending readback is consumed by the next frame start
    rb_pend_nxt = rb_pend_r & ~(serial_on & frm_fall);
    if (exec_go) begin
      last_cmd_nxt = exec_word;
      good_cnt_nxt = good_cnt_r + 16'h0001;
      if (exec_word == NO_OPERATION_WORD) begin
        mem_we = 1'b0;
      end else if (cmd.rd) begin
        rb_word_nxt = {exec_word[23:14], mem_q, 2'h0};
        rb_pend_nxt = 1'b1;
      end else begin
        mem_we = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_idx] <= cmd.data_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      sr_r <= NO_OPERATION_WORD;
      dout_r <= 1'b0;
      rb_pend_r <= 1'b0;
      rb_word_r <= NO_OPERATION_WORD;
      last_cmd_r <= NO_OPERATION_WORD;
      good_cnt_r <= CNT_RST;
      bad_cnt_r <= CNT_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sr_r <= sr_nxt;
      dout_r <= dout_nxt;
      rb_pend_r <= rb_pend_nxt;
      rb_word_r <= rb_word_nxt;
      last_cmd_r <= last_cmd_nxt;
      good_cnt_r <= good_cnt_nxt;
      bad_cnt_r <= bad_cnt_nxt;
    end
  end

  assign chain_data_out = dout_r;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // address and data are taken together, and only while no write response is still pending
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, aw_take, ar_take;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  assign aw_take = awvalid & wvalid & ~bvalid_r;
  assign ar_take = arvalid & ~rvalid_r;
  assign awready = aw_take;
  assign wready = aw_take;
  assign arready = ~rvalid_r;

  always_comb begin
    bvalid_nxt = bvalid_r & ~bready;
    bresp_nxt = bresp_r;
    toggle_nxt = toggle_r;
    rvalid_nxt = rvalid_r & ~rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (aw_take) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (awaddr)
        REG_CTRL: begin
          if (wstrb[0]) begin
            toggle_nxt = wdata[CTRL_TOGGLE_BIT];
          end
        end
        REG_STATUS, REG_LAST_CMD, REG_GOOD_CNT, REG_BAD_CNT: begin
          bresp_nxt = RESP_OKAY;
        end
        default: begin
          bresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (ar_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (araddr)
        REG_CTRL: rdata_nxt = {31'h0, toggle_r};
        REG_STATUS: rdata_nxt = {21'h0, daisy, serial_on, rb_pend_r, 1'b0, state_r, cnt_r};
        REG_LAST_CMD: rdata_nxt = {8'h00, last_cmd_r};
        REG_GOOD_CNT: rdata_nxt = {16'h0000, good_cnt_r};
        REG_BAD_CNT: rdata_nxt = {16'h0000, bad_cnt_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      toggle_r <= CTRL_TOGGLE_RST;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      toggle_r <= toggle_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic sr_top;
  logic [9:0] exec_hdr;
  assign sr_top = sr_r[23];
  assign exec_hdr = exec_word[23:14];

  property p_cnt_bound;
    cnt_r <= WORD_BITS;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("bit count above word length");

  property p_start;
    serial_on && frm_fall |=> state_r == ST_SHIFT && cnt_r == 5'h00;
  endproperty
  a_start: assert property (p_start) else $error("frame start did not clear count");

  property p_full_hold;
    serial_on && state_r == ST_FULL && !frm_fall |=> $stable(sr_r) && cnt_r == 5'h18;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("shift moved after full word");

  property p_stand_rise;
    serial_on && !daisy && state_r == ST_SHIFT && frm_rise && !sclk_fall |=> state_r == ST_SHIFT;
  endproperty
  a_stand_rise: assert property (p_stand_rise) else $error("standalone frame ended by sync rise");

  property p_shift_in;
    serial_on && state_r == ST_SHIFT && sclk_fall && !frm_fall && !(daisy && frm_rise)
      |=> sr_r[0] == $past(sync_r.din) && dout_r == $past(dout_r);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("falling edge did not sample input");

  property p_dout_rise;
    serial_on && state_r == ST_SHIFT && sclk_rise && !frm_fall && !(daisy && frm_rise) |=> dout_r == $past(sr_top);
  endproperty
  a_dout_rise: assert property (p_dout_rise) else $error("output not updated on rising edge");

  property p_latch;
    serial_on && daisy && state_r == ST_SHIFT && frm_rise && !frm_fall && cnt_r == 5'h18
      |=> last_cmd_r == $past(sr_r) && state_r == ST_IDLE;
  endproperty
  a_latch: assert property (p_latch) else $error("daisy word not latched at sync rise");

  property p_bad;
    serial_on && daisy && state_r == ST_SHIFT && frm_rise && cnt_r != 5'h18
      |=> bad_cnt_r == $past(bad_cnt_r) + 16'h0001 ##0 $stable(last_cmd_r);
  endproperty
  a_bad: assert property (p_bad) else $error("short frame was not discarded");

  property p_readback;
    exec_go && exec_word != NO_OPERATION_WORD && exec_word[22] |=> rb_pend_r && rb_word_r[23:14] == $past(exec_hdr);
  endproperty
  a_readback: assert property (p_readback) else $error("readback request not armed");

  property p_nop;
    exec_go && exec_word == NO_OPERATION_WORD |=> $stable(rb_word_r);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation frame changed state");

  property p_first_bit;
    serial_on && frm_fall && sync_r.sclk |=> dout_r == sr_top;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first readback bit missing at sync fall");

  c_stand_word: cover property (serial_on && !daisy && state_r == ST_SHIFT ##1 state_r == ST_FULL);
  c_daisy_latch: cover property (serial_on && daisy && frm_rise && cnt_r == 5'h18);
  c_bad_frame: cover property (serial_on && daisy && frm_rise && state_r == ST_SHIFT && cnt_r != 5'h18);
  c_readback: cover property (rb_pend_r ##[1:1000] frm_fall);

endmodule

// ---- bench/dshi_host.sv ----
// Purpose: serial master model that frames words onto the DAC serial port
// Assumes: sclk half period of 4 aclk cycles (80 ns period); sclk rests high between frames
// Notes: frame() must be entered just after a rising aclk edge
`timescale 1ns/1ps

module dshi_host (
  input wire logic aclk,
  input wire logic chain_data_out,
  output logic sclk,
  output logic sync_n,
  output logic din
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
  end

  // ----------------------------------------------------------------
  // one framed burst
  // ----------------------------------------------------------------
  // exactly n pulses, sync_n raised after the last one
  task automatic frame(input logic [47:0] w, input int n, output logic [47:0] rx);
    rx = '0;
    sync_n <= 1'b0;
    din <= w[n-1];
    repeat (6) @(posedge aclk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      repeat (2) @(posedge aclk);
      // chain_data_out has settled well after the rise
      rx = {rx[46:0], chain_data_out};
      repeat (2) @(posedge aclk);
      sclk <= 1'b1;
      // din moves on the rise so it is steady at the fall
      if (i > 0) din <= w[i-1];
      repeat (4) @(posedge aclk);
    end
    sync_n <= 1'b1;
    // released line: show the inverse so a stale bit cannot pass
    din <= ~din;
    repeat (8) @(posedge aclk);
  endtask
endmodule

// ---- bench/dshi_serial_bench.sv ----
// Purpose: self-checking bench for the DAC serial host port
// Assumes: AXI4-Lite tasks are entered just after a rising aclk edge
// Notes: expected words are built from the command layout, never read back first
`timescale 1ns/1ps

module dshi_serial_bench;
  import dshi_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic chain_en = 1'b0;
  logic h_sclk, h_sync_n, h_din, chain_data_out;
  dshi_pins_t pins;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int miscompares = 0;
  int checked = 0;
  localparam logic [23:0] W1 = {2'b00, 6'h05, 2'h3, 12'hABC, 2'b00};
  localparam logic [23:0] W2 = {2'b00, 6'h21, 2'h1, 12'h5A5, 2'b00};
  localparam logic [23:0] W3 = {2'b00, 6'h12, 2'h2, 12'h3C3, 2'b00};
  localparam logic [23:0] WB = {2'b10, 6'h05, 2'h3, 12'h123, 2'b00};

  always #5 aclk = ~aclk;
  // serial, clocked protocol
  assign pins = {h_sclk, h_sync_n, h_din, chain_en, 1'b1, 1'b0};

  dshi_host dshi_host_inst (.aclk(aclk), .chain_data_out(chain_data_out), .sclk(h_sclk), .sync_n(h_sync_n),
    .din(h_din));
  dshi_serial dshi_serial_inst (.aclk(aclk), .aresetn(aresetn), .pins(pins), .chain_data_out(chain_data_out),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // let bready settle low before a following request raises it again
    @(posedge aclk);
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, exp);
  endtask

  // request a readback, then clock it out with a no-op frame
  task automatic readback(input logic [23:0] req, input logic [11:0] exp);
    logic [47:0] rx;
    dshi_host_inst.frame({24'h0, req}, 24, rx);
    dshi_host_inst.frame({24'h0, NO_OPERATION_WORD}, 24, rx);
    chk(rx[23:0], {req[23:14], exp, 2'b00});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(REG_CTRL, 32'h0);
    rd(REG_GOOD_CNT, 32'h0);
    rd(REG_BAD_CNT, 32'h0);
    axr(12'h020, d, r);
    chk({d, r}, {32'h0, RESP_SLVERR});
    axw(12'h020, 32'h1, r);
    chk(r, RESP_SLVERR);
    axw(REG_GOOD_CNT, 32'hFF, r);
    chk(r, RESP_OKAY);
    rd(REG_GOOD_CNT, 32'h0);
  endtask

  task automatic t_standalone();
    logic [47:0] rx;
    logic [31:0] d;
    logic [1:0] r;
    dshi_host_inst.frame({24'h0, W1}, 24, rx);
    rd(REG_LAST_CMD, {8'h0, W1});
    axr(REG_STATUS, d, r);
    chk(d[10:9], 2'b01);
    // two extra clocks, as a free-running clock would give
    dshi_host_inst.frame({22'h0, W2, 2'b11}, 26, rx);
    rd(REG_LAST_CMD, {8'h0, W2});
    rd(REG_GOOD_CNT, 32'h2);
    // short standalone frame: sync rise is ignored, frame stays open at 10 bits
    dshi_host_inst.frame({38'h0, 10'h3FF}, 10, rx);
    axr(REG_STATUS, d, r);
    chk(d[6:0], {2'h1, 5'h0A});
    rd(REG_LAST_CMD, {8'h0, W2});
  endtask

  task automatic t_readback();
    logic [47:0] rx;
    readback({2'b01, W1[21:14], 14'h0}, 12'hABC);
    rd(REG_LAST_CMD, 32'h0);
    dshi_host_inst.frame(48'h0, 24, rx);
    chk(rx[23:0], 24'h0);
  endtask

  task automatic t_toggle();
    logic [47:0] rx;
    logic [1:0] r;
    axw(REG_CTRL, 32'h1, r);
    dshi_host_inst.frame({24'h0, WB}, 24, rx);
    readback({2'b01, W1[21:14], 14'h0}, 12'hABC);
    readback({2'b11, W1[21:14], 14'h0}, 12'h123);
  endtask

  task automatic t_daisy();
    logic [47:0] rx;
    chain_en <= 1'b1;
    @(posedge aclk);
    dshi_host_inst.frame({W3, W2}, 48, rx);
    chk(rx, {24'h0, W3});
    rd(REG_LAST_CMD, {8'h0, W2});
    dshi_host_inst.frame({38'h0, 10'h3FF}, 10, rx);
    rd(REG_BAD_CNT, 32'h1);
    rd(REG_LAST_CMD, {8'h0, W2});
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_regs();
    t_standalone();
    t_readback();
    t_toggle();
    t_daisy();
    finish_test();
  end

  // the whole run needs about 3000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test();
  end
endmodule
